// *** rtl/bsj_exec.sv ***
`include "bsj_cfg.svh"
// --------------------------------------------------------------
// Bit set, bit clear and absolute jump executor
// --------------------------------------------------------------
// Behaviour
// - Prefix CB then 11-bbb-rrr sets the chosen register bit only.
// - Bit code 000 picks bit 0 and 111 picks bit 7, ascending.
// - Register codes B..L are 000..101, A is 111, 110 means memory.
// - The pointer form sets a bit at the pointer pair in 4 M, 15 T.
// - The x index form sets a bit at x plus d in 6 M, 23 T.
// - FD CB d 11-bbb-110 sets a bit at y plus signed d.
// - The 10-bbb forms, plain or DD/FD prefixed, clear a bit.
// - Bit clear takes 8, 15 or 23 states for register, pointer, index.
// - C3 is followed by the low then the high target byte.
// - The jump loads the counter and fetches there, 3 M and 10 T.
module bsj_exec
  import bsj_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // External memory bus.
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Architectural state seen from outside.
  output logic [15:0] program_counter,
  output logic [7:0] flags,
  output logic [63:0] regs_flat,
  input wire logic [15:0] memory_pointer_pair,
  input wire logic [15:0] index_pair_x,
  input wire logic [15:0] index_pair_y,
  // Status.
  output logic insn_done,
  output logic [4:0] insn_states,
  output logic [2:0] insn_mcycles,
  output logic illegal_op
);
  bsj_mem_if mif ();
  bsj_state_t state_q;
  bsj_form_t form_q;
  logic [15:0] pc_q;
  logic [7:0] regs_q [8];
  logic [7:0] flags_q;
  logic [1:0] prefix_q;
  logic [1:0] opnd_cnt_q;
  logic is_jump_q;
  logic [7:0] op_q;
  logic [7:0] disp_q;
  logic [7:0] lo_q;
  logic [15:0] ea_q;
  logic [4:0] states_q;
  logic [4:0] wait_q;
  logic done_q;
  logic [4:0] tstates_q;
  logic [2:0] mcyc_q;
  logic illegal_q;
  logic [7:0] fetched;

  // Modify one bit of a byte: set or clear per the group field.
  function automatic logic [7:0] bsj_apply(input logic [7:0] val,
                                           input logic [7:0] op);
    logic [7:0] mask;
    mask = 8'h01 << op[`BSJ_BIT_HI:`BSJ_BIT_LO];
    if (op[`BSJ_GRP_HI:`BSJ_GRP_LO] == `BSJ_GRP_SET)
      bsj_apply = val | mask;
    else
      bsj_apply = val & ~mask;
  endfunction

  // A byte in the bit group that this block executes.
  function automatic logic bsj_is_bitop(input logic [7:0] op);
    bsj_is_bitop = op[`BSJ_GRP_HI];
  endfunction

  bsj_bus_port u_port (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mif(mif),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );

  assign fetched = mif.rdata;

  // ------------------------------------------------------------
  // Bus requests
  // ------------------------------------------------------------
  // One request per phase; the request drops while the answer is due.
  always_comb
  begin
    mif.req = 1'b0;
    mif.wr = 1'b0;
    mif.addr = pc_q;
    mif.wdata = bsj_apply(fetched, op_q);
    case (state_q)
      BSJ_FETCH, BSJ_OPND:
        mif.req = ~mif.done;
      BSJ_READ:
      begin
        mif.req = ~mif.done;
        mif.addr = ea_q;
      end
      BSJ_WRITE:
      begin
        mif.req = 1'b1;
        mif.wr = 1'b1;
        mif.addr = ea_q;
      end
      default:
        mif.req = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Each edge counts one clock state; the end of an instruction is
  // held back in WAIT until its documented state count is reached.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= BSJ_FETCH;
      form_q <= BSJ_FORM_REG;
      pc_q <= `BSJ_PC_RST;
      prefix_q <= 2'h0;
      opnd_cnt_q <= 2'h0;
      is_jump_q <= 1'b0;
      op_q <= `BSJ_BYTE_RST;
      disp_q <= `BSJ_BYTE_RST;
      lo_q <= `BSJ_BYTE_RST;
      ea_q <= `BSJ_PC_RST;
      states_q <= 5'h00;
      wait_q <= 5'h00;
      done_q <= 1'b0;
      tstates_q <= 5'h00;
      mcyc_q <= 3'h0;
      illegal_q <= 1'b0;
      for (int i = 0; i < 8; i++)
        regs_q[i] <= `BSJ_BYTE_RST;
    end
    else
    begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      states_q <= states_q + 5'h01;
      case (state_q)
        BSJ_FETCH:
          if (mif.done)
          begin
            pc_q <= pc_q + 16'h0001;
            // The fetch request and its answer are two states already.
            if (prefix_q == 2'h0)
              states_q <= 5'h02;
            if (fetched == `BSJ_OP_JUMP && prefix_q == 2'h0)
            begin
              is_jump_q <= 1'b1;
              opnd_cnt_q <= 2'h0;
              state_q <= BSJ_OPND;
            end
            else if (fetched == `BSJ_OP_PREFIX_IXX && prefix_q == 2'h0)
              prefix_q <= 2'h1;
            else if (fetched == `BSJ_OP_PREFIX_IXY && prefix_q == 2'h0)
              prefix_q <= 2'h2;
            else if (fetched == `BSJ_OP_PREFIX_BIT)
            begin
              is_jump_q <= 1'b0;
              opnd_cnt_q <= (prefix_q != 2'h0) ? 2'h0 : 2'h1;
              state_q <= BSJ_OPND;
            end
            else
            begin
              illegal_q <= 1'b1;
              prefix_q <= 2'h0;
            end
          end
        BSJ_OPND:
          if (mif.done)
          begin
            pc_q <= pc_q + 16'h0001;
            opnd_cnt_q <= opnd_cnt_q + 2'h1;
            if (is_jump_q)
            begin
              if (opnd_cnt_q == 2'h0)
                lo_q <= fetched;
              else
              begin
                pc_q <= {fetched, lo_q};
                wait_q <= `BSJ_T_JUMP;
                tstates_q <= `BSJ_T_JUMP;
                mcyc_q <= `BSJ_M_JUMP;
                state_q <= BSJ_WAIT;
              end
            end
            else if (opnd_cnt_q == 2'h0)
              disp_q <= fetched;
            else
            begin
              op_q <= fetched;
              if (!bsj_is_bitop(fetched))
              begin
                illegal_q <= 1'b1;
                prefix_q <= 2'h0;
                state_q <= BSJ_FETCH;
              end
              else if (prefix_q != 2'h0)
              begin
                form_q <= BSJ_FORM_IDX;
                state_q <= BSJ_CALC;
              end
              else if (fetched[`BSJ_REG_HI:`BSJ_REG_LO] == `BSJ_REG_MEM)
              begin
                form_q <= BSJ_FORM_PTR;
                ea_q <= memory_pointer_pair;
                state_q <= BSJ_READ;
              end
              else
              begin
                form_q <= BSJ_FORM_REG;
                regs_q[fetched[`BSJ_REG_HI:`BSJ_REG_LO]] <=
                  bsj_apply(regs_q[fetched[`BSJ_REG_HI:`BSJ_REG_LO]],
                            fetched);
                wait_q <= `BSJ_T_REG;
                tstates_q <= `BSJ_T_REG;
                mcyc_q <= `BSJ_M_REG;
                state_q <= BSJ_WAIT;
              end
            end
          end
        BSJ_CALC:
        begin
          // Signed displacement is sign extended before the add.
          ea_q <= ((prefix_q == 2'h1) ? index_pair_x : index_pair_y) +
                  {{8{disp_q[7]}}, disp_q};
          state_q <= BSJ_READ;
        end
        BSJ_READ:
          if (mif.done)
            state_q <= BSJ_WRITE;
        BSJ_WRITE:
        begin
          wait_q <= (form_q == BSJ_FORM_IDX) ? `BSJ_T_IDX : `BSJ_T_MEM;
          tstates_q <= (form_q == BSJ_FORM_IDX) ? `BSJ_T_IDX :
                       `BSJ_T_MEM;
          mcyc_q <= (form_q == BSJ_FORM_IDX) ? `BSJ_M_IDX : `BSJ_M_MEM;
          state_q <= BSJ_WAIT;
        end
        default:
          if (states_q + 5'h01 >= wait_q)
          begin
            done_q <= 1'b1;
            prefix_q <= 2'h0;
            is_jump_q <= 1'b0;
            state_q <= BSJ_FETCH;
          end
      endcase
    end
  end

  // Flags are never written by this block, so they keep their value.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_q <= `BSJ_BYTE_RST;
    else
      flags_q <= flags_q;
  end

  // Flatten the register file, B in the low byte; slot 6 stays unused.
  for (genvar g = 0; g < 8; g++)
  begin : g_flat
    assign regs_flat[g*8 +: 8] = regs_q[g];
  end

  assign program_counter = pc_q;
  assign flags = flags_q;
  assign insn_done = done_q;
  assign insn_states = tstates_q;
  assign insn_mcycles = mcyc_q;
  assign illegal_op = illegal_q;
endmodule

// *** rtl/bsj_cfg.svh ***
`ifndef BSJ_CFG_SVH
`define BSJ_CFG_SVH
// Opcode and prefix bytes.
`define BSJ_OP_PREFIX_BIT 8'hcb
`define BSJ_OP_PREFIX_IXX 8'hdd
`define BSJ_OP_PREFIX_IXY 8'hfd
`define BSJ_OP_JUMP 8'hc3
// Field positions inside the second opcode byte.
`define BSJ_GRP_HI 7
`define BSJ_GRP_LO 6
`define BSJ_BIT_HI 5
`define BSJ_BIT_LO 3
`define BSJ_REG_HI 2
`define BSJ_REG_LO 0
// Group and register field codes.
`define BSJ_GRP_SET 2'h3
`define BSJ_GRP_CLR 2'h2
`define BSJ_REG_MEM 3'h6
`define BSJ_REG_A 3'h7
// Instruction lengths in clock states.
`define BSJ_T_REG 5'h08
`define BSJ_T_MEM 5'h0f
`define BSJ_T_IDX 5'h17
`define BSJ_T_JUMP 5'h0a
// Instruction lengths in machine cycles.
`define BSJ_M_REG 3'h2
`define BSJ_M_MEM 3'h4
`define BSJ_M_IDX 3'h6
`define BSJ_M_JUMP 3'h3
// Reset values.
`define BSJ_PC_RST 16'h0000
`define BSJ_BYTE_RST 8'h00
`endif

// *** rtl/bsj_pkg.sv ***
package bsj_pkg;
  // Execution phases, Gray coded along fetch, operands, calc, read, write, wait.
  typedef enum logic [2:0] {
    BSJ_FETCH = 3'h0,
    BSJ_OPND = 3'h1,
    BSJ_CALC = 3'h3,
    BSJ_READ = 3'h2,
    BSJ_WRITE = 3'h6,
    BSJ_WAIT = 3'h7
  } bsj_state_t;
  // Operand form of a decoded bit instruction.
  typedef enum logic [1:0] {
    BSJ_FORM_REG = 2'h0,
    BSJ_FORM_PTR = 2'h1,
    BSJ_FORM_IDX = 2'h2
  } bsj_form_t;
endpackage

// *** rtl/bsj_mem_if.sv ***
interface bsj_mem_if;
  // Request to the bus port and answer from it.
  logic req;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;
  modport core (output req, wr, addr, wdata, input rdata, done);
  modport port (input req, wr, addr, wdata, output rdata, done);
endinterface

// *** rtl/bsj_bus_port.sv ***
`include "bsj_cfg.svh"
// --------------------------------------------------------------
// Single-cycle bus port: one access per request, answer next edge.
// --------------------------------------------------------------
module bsj_bus_port
  import bsj_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Core side.
  bsj_mem_if.port mif,
  // External memory bus.
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  // Strobes are combinational so the memory sees them in the request cycle.
  assign mem_rd = mif.req & ~mif.wr;
  assign mem_wr = mif.req & mif.wr;
  assign mem_addr = mif.addr;
  assign mem_wdata = mif.wdata;

  // Read data is captured so the core sees a stable byte with done.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mif.rdata <= `BSJ_BYTE_RST;
      mif.done <= 1'b0;
    end
    else
    begin
      // Only a read updates the byte, so it still stands for the write
      // back two cycles later, when the idle bus shows something else.
      if (mem_rd)
        mif.rdata <= mem_rdata;
      mif.done <= mif.req;
    end
  end
endmodule

// *** dv/bsj_exec_properties.sv ***
// ----------------------------------------------------------------
// Bus and status checks for the bit and jump executor.
// ----------------------------------------------------------------
module bsj_exec_properties (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Memory bus.
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // State and status.
  input wire logic [15:0] program_counter,
  input wire logic [7:0] flags,
  input wire logic insn_done,
  input wire logic [4:0] insn_states,
  input wire logic [2:0] insn_mcycles,
  input wire logic illegal_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A write reuses the address of the read two cycles before it; the
  // cycle between carries the read's answer.
  rd_wr_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write requested together");
  read_single_a: assert property (mem_rd |=> !mem_rd)
    else $error("read request held too long");
  wr_after_rd_a: assert property (mem_wr |->
    $past(mem_rd, 2) && mem_addr == $past(mem_addr, 2))
    else $error("write not preceded by read of same address");
  one_bit_a: assert property (mem_wr |->
    $countones(mem_wdata ^ $past(mem_rdata, 2)) <= 1)
    else $error("write back changed more than one bit");
  flags_kept_a: assert property (flags == 8'h00)
    else $error("condition flags changed");
  figures_pair_a: assert property (insn_done |->
    (insn_states == 5'h08 && insn_mcycles == 3'h2) ||
    (insn_states == 5'h0f && insn_mcycles == 3'h4) ||
    (insn_states == 5'h17 && insn_mcycles == 3'h6) ||
    (insn_states == 5'h0a && insn_mcycles == 3'h3))
    else $error("state and cycle figures do not match");
  done_gap_a: assert property (insn_done |=> !insn_done [*7])
    else $error("instructions finished too close together");
  legal_only_a: assert property (!illegal_op)
    else $error("legal opcode reported illegal");
  jump_fetch_a: assert property (insn_done && insn_states == 5'h0a |->
    ##[0:2] (mem_rd && mem_addr == program_counter))
    else $error("no fetch at the jump target");
  // Main scenarios.
  cover property (mem_wr);
  cover property (insn_done && insn_states == 5'h17);
  cover property (insn_done && insn_states == 5'h0a);
endmodule
bind bsj_exec bsj_exec_properties i_bsj_exec_properties (.ref_clk,
  .reset_n, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata,
  .program_counter, .flags, .insn_done, .insn_states, .insn_mcycles,
  .illegal_op);

// *** dv/bsj_mem_model.sv ***
// ----------------------------------------------------------------
// Zero-wait external memory.
// ----------------------------------------------------------------
module bsj_mem_model (
  // Clock and bus.
  input wire logic ref_clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;
  // Idle bus shows the inverse of the last byte, so stale data never passes.
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
  // Writes land on the edge that ends the request cycle.
  always @(posedge ref_clk)
  begin
    if (mem_rd) last_q <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

// *** dv/bsj_exec_tb.sv ***
`include "bsj_cfg.svh"
// ----------------------------------------------------------------
// Random program of bit and jump instructions, checked per step.
// ----------------------------------------------------------------
module bsj_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 48;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mem_rd, mem_wr, insn_done, illegal_op;
  logic [15:0] mem_addr, program_counter;
  logic [7:0] mem_wdata, mem_rdata, flags;
  logic [63:0] regs_flat, regs;
  logic [15:0] memory_pointer_pair = 16'h8000;
  logic [15:0] index_pair_x = 16'hc000;
  logic [15:0] index_pair_y = 16'hc000;
  logic [4:0] insn_states;
  logic [2:0] insn_mcycles;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'd34;
  logic [15:0] hl_a [N], ix_a [N], iy_a [N], ea_a [N], pc_a [N];
  logic [7:0] byte_a [N];
  logic [4:0] st_a [N];
  logic [2:0] mc_a [N];
  logic [63:0] regs_a [N];
  bit mem_a [N], jmp_a [N];
  logic [7:0] shadow [bit [15:0]];

  // Clock at 250 MHz.
  always #2 ref_clk = ~ref_clk;

  bsj_exec i_bsj_exec (.ref_clk, .reset_n, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rdata, .program_counter, .flags, .regs_flat,
    .memory_pointer_pair, .index_pair_x, .index_pair_y, .insn_done,
    .insn_states, .insn_mcycles, .illegal_op);
  bsj_mem_model i_bsj_mem_model (.ref_clk, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rdata);

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [7:0] modify(logic [7:0] v, logic [2:0] b, logic s);
    return s ? v | (8'h01 << b) : v & ~(8'h01 << b);
  endfunction

  task put(input logic [15:0] a, input logic [7:0] v);
    i_bsj_mem_model.mem[a] = v;
  endtask

  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The whole program is laid down before reset, so fetches never race it.
  task gen;
    logic [31:0] r, s;
    logic [15:0] p, ea;
    logic [7:0] op2, d;
    logic [2:0] g;
    logic [1:0] f;
    p = 16'h0000;
    regs = 64'h0;
    for (int k = 0; k < N; k++)
    begin
      r = rnd();
      s = rnd();
      // The first sixteen walk every bit and register code.
      if (k < 16) r[11:0] = {3'(k), 3'(k), ~k[3], 3'h1, 2'h0};
      // Two index forms carry the extreme displacements.
      if (k == 17 || k == 18) r[4:0] = {3'h1, 1'b1, k[0]};
      hl_a[k] = {1'b1, s[14:0]};
      ix_a[k] = {2'b11, s[29:16]};
      iy_a[k] = {2'b11, s[13:0]};
      d = (k == 17) ? 8'h80 : (k == 18) ? 8'h7f : r[23:16];
      f = r[1:0];
      g = (r[11:9] == 3'h6) ? 3'h7 : r[11:9];
      op2 = {1'b1, r[5], r[8:6], f == 2'h0 ? g : 3'h6};
      jmp_a[k] = (r[4:2] == 3'h0);
      mem_a[k] = !jmp_a[k] && f != 2'h0;
      if (jmp_a[k])
      begin
        pc_a[k] = p + 16'd19 + 16'(r[17:12]);
        put(p, `BSJ_OP_JUMP);
        put(p + 16'd1, pc_a[k][7:0]);
        put(p + 16'd2, pc_a[k][15:8]);
        p = pc_a[k];
        st_a[k] = 5'h0a;
        mc_a[k] = 3'h3;
      end
      else
      begin
        ea = (f == 2'h1) ? hl_a[k] : (f == 2'h2 ? ix_a[k] : iy_a[k]) +
          {{8{d[7]}}, d};
        if (f[1])
        begin
          put(p, f == 2'h2 ? `BSJ_OP_PREFIX_IXX : `BSJ_OP_PREFIX_IXY);
          put(p + 16'd1, `BSJ_OP_PREFIX_BIT);
          put(p + 16'd2, d);
          put(p + 16'd3, op2);
          p += 16'd4;
        end
        else
        begin
          put(p, `BSJ_OP_PREFIX_BIT);
          put(p + 16'd1, op2);
          p += 16'd2;
        end
        if (f == 2'h0)
          regs[{g, 3'h0} +: 8] = modify(regs[{g, 3'h0} +: 8], r[8:6], r[5]);
        else
        begin
          if (!shadow.exists(ea))
          begin
            shadow[ea] = s[31:24];
            put(ea, s[31:24]);
          end
          shadow[ea] = modify(shadow[ea], r[8:6], r[5]);
          byte_a[k] = shadow[ea];
        end
        ea_a[k] = ea;
        st_a[k] = f == 2'h0 ? 5'h08 : (f == 2'h1 ? 5'h0f : 5'h17);
        mc_a[k] = f == 2'h0 ? 3'h2 : (f == 2'h1 ? 3'h4 : 3'h6);
      end
      regs_a[k] = regs;
    end
  endtask

  // Counts the edges from the previous end pulse, which is the length.
  task wait_done(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (insn_done !== 1'b1 && n < 40);
    chk("insn_done", 1'b1, insn_done);
  endtask

  // Main sequence: reset, then check each instruction as it finishes.
  initial
  begin
    int cyc;
    gen();
    memory_pointer_pair = hl_a[0];
    index_pair_x = ix_a[0];
    index_pair_y = iy_a[0];
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    for (int k = 0; k < N; k++)
    begin
      wait_done(cyc);
      chk("cycles", st_a[k], 64'(cyc));
      chk("insn_states", st_a[k], insn_states);
      chk("insn_mcycles", mc_a[k], insn_mcycles);
      chk("regs_flat", regs_a[k], regs_flat);
      chk("flags", 8'h00, flags);
      if (mem_a[k])
        chk("memory byte", byte_a[k], i_bsj_mem_model.mem[ea_a[k]]);
      if (jmp_a[k])
        chk("program_counter", pc_a[k], program_counter);
      // Pointers move only after the edge that ends the instruction.
      if (k + 1 < N)
      begin
        memory_pointer_pair = hl_a[k + 1];
        index_pair_x = ix_a[k + 1];
        index_pair_y = iy_a[k + 1];
      end
    end
    close_out();
  end

  // Watchdog: the program needs well under 2000 cycles.
  initial
  begin
    #20000;
    mismatches++;
    close_out();
  end
endmodule
